// file: mpr_regs.sv
// Message-passing capability register bank
`timescale 1ns/1ps
module mpr_regs #(
  parameter logic SRC_DATA_MSG = 1'b1,
  parameter logic SRC_DOORBELL = 1'b1,
  parameter logic DST_DATA_MSG = 1'b1,
  parameter logic DST_DOORBELL = 1'b1,
  parameter logic [3:0] SRC_IMPL = 4'h0,
  parameter logic [3:0] DST_IMPL = 4'h0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire mpr_pkg::mpr_req_type i_maint_req,
  output mpr_pkg::mpr_rsp_type o_maint_rsp
);
  import mpr_pkg::*;

  // Configuration space regions
  typedef enum logic [2:0] {
    RGN_CAR = 3'h0,
    RGN_CSR = 3'h1,
    RGN_EXT = 3'h2,
    RGN_IMP = 3'h3
  } mpr_region_type;

  // Kinds of maintenance access
  typedef enum logic [1:0] {
    ACC_IDLE = 2'h0,
    ACC_READ = 2'h1,
    ACC_WRITE = 2'h2
  } mpr_access_type;

  logic req_valid;
  logic req_write;
  logic [ADDR_W-1:0] req_addr;
  logic [ADDR_W-1:0] req_word_addr;
  logic [3:0] car_idx;
  mpr_region_type region;
  mpr_access_type access;
  logic [DATA_W-1:0] src_word;
  logic [DATA_W-1:0] dst_word;
  logic [DATA_W-1:0] defined_mask;
  logic [DATA_W-1:0] car_rd;
  logic [DATA_W-1:0] region_rd;
  logic [DATA_W-1:0] rd_d;
  logic valid_d;
  logic error_d;
  logic valid_q;
  logic error_q;
  logic [DATA_W-1:0] rdata_q;

  // Request fields, low address bits ignored
  assign req_valid = i_maint_req.valid;
  assign req_write = i_maint_req.write;
  assign req_addr = i_maint_req.addr;
  assign req_word_addr = {req_addr[ADDR_W-1:2], 2'b00};
  assign car_idx = req_word_addr[5:2];

  // Access kind
  always_comb begin
    access = ACC_IDLE;
    if (req_valid) begin
      if (req_write) begin
        access = ACC_WRITE;
      end else begin
        access = ACC_READ;
      end
    end
  end

  // Region of the addressed word
  always_comb begin
    region = RGN_IMP;
    if (req_word_addr < OFS_CSR_BASE) begin
      region = RGN_CAR;
    end else if (req_word_addr < OFS_EXT_BASE) begin
      region = RGN_CSR;
    end else if (req_word_addr < OFS_IMP_BASE) begin
      region = RGN_EXT;
    end
  end

  // Fixed capability bits, big-endian numbering
  for (genvar g = 0; g < DATA_W; g++) begin : g_cap_bit
    if (g == BIT_DATA_MSG) begin : g_msg
      assign src_word[g] = SRC_DATA_MSG;
      assign dst_word[g] = DST_DATA_MSG;
      assign defined_mask[g] = 1'b1;
    end else if (g == BIT_DOORBELL) begin : g_bell
      assign src_word[g] = SRC_DOORBELL;
      assign dst_word[g] = DST_DOORBELL;
      assign defined_mask[g] = 1'b1;
    end else if (g == IMPA_HI) begin : g_impa_hi
      assign src_word[g] = SRC_IMPL[3];
      assign dst_word[g] = DST_IMPL[3];
      assign defined_mask[g] = 1'b1;
    end else if (g == IMPA_LO) begin : g_impa_lo
      assign src_word[g] = SRC_IMPL[2];
      assign dst_word[g] = DST_IMPL[2];
      assign defined_mask[g] = 1'b1;
    end else if (g == IMPB_HI) begin : g_impb_hi
      assign src_word[g] = SRC_IMPL[1];
      assign dst_word[g] = DST_IMPL[1];
      assign defined_mask[g] = 1'b1;
    end else if (g == IMPB_LO) begin : g_impb_lo
      assign src_word[g] = SRC_IMPL[0];
      assign dst_word[g] = DST_IMPL[0];
      assign defined_mask[g] = 1'b1;
    end else begin : g_rsvd
      assign src_word[g] = 1'b0;
      assign dst_word[g] = 1'b0;
      assign defined_mask[g] = 1'b0;
    end
  end

  // Capability region word table
  always_comb begin
    car_rd = RD_ZERO;
    unique case (car_idx)
      OFS_SRC_OPS[5:2]: begin
        car_rd = src_word & defined_mask;
      end
      OFS_DST_OPS[5:2]: begin
        car_rd = dst_word & defined_mask;
      end
      default: begin
        car_rd = RD_ZERO;
      end
    endcase
  end

  // Read word by region
  always_comb begin
    region_rd = RD_ZERO;
    unique case (region)
      RGN_CAR: begin
        region_rd = car_rd;
      end
      RGN_CSR: begin
        region_rd = RD_ZERO;
      end
      RGN_EXT: begin
        region_rd = RD_ZERO;
      end
      RGN_IMP: begin
        region_rd = RD_ZERO;
      end
      default: begin
        region_rd = RD_ZERO;
      end
    endcase
  end

  // Read data by access kind, writes discarded
  always_comb begin
    rd_d = RD_ZERO;
    unique case (access)
      ACC_IDLE: begin
        rd_d = RD_ZERO;
      end
      ACC_READ: begin
        rd_d = region_rd;
      end
      ACC_WRITE: begin
        rd_d = RD_ZERO;
      end
      default: begin
        rd_d = RD_ZERO;
      end
    endcase
  end

  // One answer per accepted request
  always_comb begin
    valid_d = 1'b0;
    if (access != ACC_IDLE) begin
      valid_d = 1'b1;
    end
  end

  // Every access completes as done
  always_comb begin
    error_d = 1'b0;
    if (req_valid) begin
      error_d = STAT_DONE[0];
    end
  end

  // Response valid
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  // Completion status
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      error_q <= 1'b0;
    end else begin
      error_q <= error_d;
    end
  end

  // Read data, zero when no read
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= RD_ZERO;
    end else begin
      rdata_q <= rd_d;
    end
  end

  // Response assembled from the registers
  assign o_maint_rsp = '{
    valid: valid_q,
    error: error_q,
    rdata: rdata_q
  };
endmodule : mpr_regs

// file: mpr_pkg.sv
// Package for the message-passing configuration register bank
package mpr_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 32;
  localparam logic [23:0] OFS_SRC_OPS = 24'h000018;
  localparam logic [23:0] OFS_DST_OPS = 24'h00001C;
  localparam logic [23:0] OFS_CSR_BASE = 24'h000040;
  localparam logic [23:0] OFS_EXT_BASE = 24'h000100;
  localparam logic [23:0] OFS_IMP_BASE = 24'h010000;
  // Big-endian bit n maps to vector index 31-n
  localparam int unsigned BIT_DATA_MSG = 31 - 20;
  localparam int unsigned BIT_DOORBELL = 31 - 21;
  localparam int unsigned IMPA_HI = 31 - 14;
  localparam int unsigned IMPA_LO = 31 - 15;
  localparam int unsigned IMPB_HI = 31 - 30;
  localparam int unsigned IMPB_LO = 31 - 31;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
  localparam logic [1:0] STAT_DONE = 2'h0;

  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] addr;
    logic [31:0] wdata;
  } mpr_req_type;

  typedef struct packed {
    logic valid;
    logic error;
    logic [31:0] rdata;
  } mpr_rsp_type;
endpackage : mpr_pkg

// file: mpr_regs_assertions.sv
// Response checker for the register bank
`timescale 1ns/1ps
module mpr_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire mpr_pkg::mpr_req_type i_maint_req,
  input wire mpr_pkg::mpr_rsp_type o_maint_rsp
);
  import mpr_pkg::*;
  wire logic cr = i_maint_req.valid && !i_maint_req.write && i_maint_req.addr[23:3] == 21'h3;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  property p_ans; i_maint_req.valid |=> o_maint_rsp[33:32] == 2'h2; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_idle; !i_maint_req.valid |=> o_maint_rsp == '0; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_zero; i_maint_req.valid && !cr |=> o_maint_rsp.rdata == RD_ZERO; endproperty
  a_zero: assert property (p_zero) else $error("nonzero data");
  property p_cap; cr |=> o_maint_rsp.rdata == 32'h00000C00; endproperty
  a_cap: assert property (p_cap) else $error("bad word");
  property p_err; i_maint_req.valid |=> !o_maint_rsp.error; endproperty
  a_err: assert property (p_err) else $error("error flagged");
  property p_wr; i_maint_req.valid && i_maint_req.write |=> o_maint_rsp.rdata == RD_ZERO; endproperty
  a_wr: assert property (p_wr) else $error("write returned data");
  cover property (cr);
  cover property (i_maint_req.valid && i_maint_req.write);
  cover property (i_maint_req.valid [*2]);
endmodule : mpr_chk

// file: mpr_host.sv
// Remote element issuing maintenance accesses
`timescale 1ns/1ps
module mpr_host (
  input wire logic i_ref_clk,
  input wire mpr_pkg::mpr_rsp_type i_rsp,
  output mpr_pkg::mpr_req_type o_req = '0
);
  import mpr_pkg::*;
  // One request per call, released once the answer is taken
  task xfer(input logic w, input logic [23:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic [1:0] s);
    o_req = '{1'b1, w, a, d};
    @(posedge i_ref_clk);
    #1;
    q = i_rsp.rdata;
    s = {i_rsp.valid, i_rsp.error};
    o_req = '0;
    @(posedge i_ref_clk);
    #1;
  endtask : xfer
endmodule : mpr_host

// file: tb_top.sv
// Testbench for the register bank
`timescale 1ns/1ps
module tb_top;
  import mpr_pkg::*;
  logic i_ref_clk = 1'h0;
  logic i_rst_b = 1'h0;
  mpr_req_type i_maint_req;
  mpr_rsp_type o_maint_rsp;
  localparam logic [31:0] CAP_WORD = 32'h00000C00;
  localparam logic [31:0] CAP_MASK = 32'h00030C03;
  logic [31:0] q;
  logic [1:0] s;
  int errors = 0;
  int n_compared = 0;
  always #2 i_ref_clk = ~i_ref_clk;
  mpr_regs mpr_regs_i (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_maint_req(i_maint_req),
    .o_maint_rsp(o_maint_rsp)
  );
  mpr_host mpr_host_i (.i_ref_clk(i_ref_clk), .i_rsp(o_maint_rsp), .o_req(i_maint_req));
  task cmp_data(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", name, e, g);
    end
  endtask : cmp_data
  task cmp_stat(input logic [1:0] g);
    n_compared++;
    if (g !== 2'h2) begin
      errors++;
      $display("unexpected status exp %h got %h", 2'h2, g);
    end
  endtask : cmp_stat
  task t_caps(input logic [23:0] a);
    mpr_host_i.xfer(1'b0, a, '0, q, s);
    cmp_stat(s);
    cmp_data("cap_word", CAP_WORD, q);
    cmp_data("cap_defined", CAP_WORD, q & CAP_MASK);
    mpr_host_i.xfer(1'b1, a, q ^ CAP_WORD, q, s);
    cmp_stat(s);
    cmp_data("write_rdata", RD_ZERO, q);
    mpr_host_i.xfer(1'b0, a, '0, q, s);
    cmp_data("cap_after_write", CAP_WORD, q);
  endtask : t_caps
  task t_undef(input logic [23:0] a);
    mpr_host_i.xfer(1'b1, a, '1, q, s);
    cmp_stat(s);
    mpr_host_i.xfer(1'b0, a, '0, q, s);
    cmp_stat(s);
    cmp_data("undef_rdata", RD_ZERO, q);
  endtask : t_undef
  task give_verdict;
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (16) @(posedge i_ref_clk);
    #1 i_rst_b = 1'h1;
    @(posedge i_ref_clk) #1 t_caps(OFS_SRC_OPS);
    t_caps(OFS_DST_OPS);
    t_caps(24'h00001B);
    t_undef(24'h000014);
    t_undef(24'h000020);
    t_undef(24'h000040);
    t_undef(24'h000100);
    t_undef(24'h010000);
    t_undef(24'hFFFFFC);
    give_verdict;
  end
  initial #2000 begin
    errors++;
    give_verdict;
  end
endmodule : tb_top
bind mpr_regs mpr_chk mpr_chk_i (
  .i_ref_clk(i_ref_clk),
  .i_rst_b(i_rst_b),
  .i_maint_req(i_maint_req),
  .o_maint_rsp(o_maint_rsp)
);
